//--- hw/lsp_defines.vh
`ifndef LSP_DEFINES_VH
`define LSP_DEFINES_VH
// Port A register indices; the byte address is four times the index
`define LSP_IDX_PA_LATCH 16'hFFDD
`define LSP_IDX_PA_DIR 16'hFFED
`define LSP_ADDR_PA_LATCH 18'h3FF74
`define LSP_ADDR_PA_DIR 18'h3FFB4
// Own register byte offsets
`define LSP_ADDR_P8_LATCH 12'h000
`define LSP_ADDR_P8_DIR 12'h004
`define LSP_ADDR_P8_READ 12'h008
`define LSP_ADDR_PA_READ 12'h00C
`define LSP_ADDR_LCD_CTRL 12'h010
`define LSP_ADDR_PWR_MODE 12'h014
// Reset values
`define LSP_RST_PA_LATCH 8'hF0
`define LSP_RST_PA_DIR 8'hF0
`define LSP_RST_P8 8'h00
`define LSP_RST_PA_BITS 4'h0
`define LSP_RST_LCD_CTRL 5'h00
// Fields of the LCD pin control register
`define LSP_LCD_SGS_LSB 0
`define LSP_LCD_SGS_MSB 3
`define LSP_LCD_SGX_BIT 4
// Power mode codes
`define LSP_PM_ACTIVE 3'h0
`define LSP_PM_SUBACTIVE 3'h1
`define LSP_PM_SLEEP 3'h2
`define LSP_PM_SUBSLEEP 3'h3
`define LSP_PM_WATCH 3'h4
`define LSP_PM_STANDBY 3'h5
`endif

//--- hw/lsp_pin_cell.v
`timescale 1ns/10ps
`include "lsp_defines.vh"
// One pin: GPIO or an alternate output, with low-power hold and float
module lsp_pin_cell
(
  input wire pclk, // Clock
  input wire presetn, // Async reset, active low
  input wire alt_sel, // Alternate function selected
  input wire alt_val, // Alternate output value
  input wire dir_bit, // Direction bit, 1 is output
  input wire latch_bit, // Output latch bit
  input wire [2:0] pwr_mode, // Power mode
  output reg pin_out, // Pin output value
  output reg pin_oe // Pin output enable
);
  wire hold;
  wire float;
  assign hold = (pwr_mode == `LSP_PM_SLEEP) || (pwr_mode == `LSP_PM_SUBSLEEP) ||
    (pwr_mode == `LSP_PM_WATCH);
  assign float = (pwr_mode == `LSP_PM_STANDBY);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else if (float)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else if (!hold)
    begin
      pin_out <= alt_sel ? alt_val : latch_bit;
      pin_oe <= alt_sel | dir_bit;
    end
  end
endmodule

//--- hw/lsp_ports.v
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`include "lsp_defines.vh"
module lsp_ports
(
  input wire pclk, // Clock, 10 MHz
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB write
  input wire [17:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  input wire [3:0] pstrb, // APB byte strobes
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  input wire [7:0] p8_pin_in, // Port8 pin levels
  output wire [7:0] p8_pin_out, // Port8 pin output values
  output wire [7:0] p8_pin_oe, // Port8 pin output enables
  input wire [3:0] pa_pin_in, // Port A pin levels
  output wire [3:0] pa_pin_out, // Port A pin output values
  output wire [3:0] pa_pin_oe, // Port A pin output enables
  input wire [8:0] lcd_column_drive, // Column drive 32..24, bit k is column k+24
  input wire [3:0] lcd_common_drive, // Common drive 4..1, bit k is common k+1
  input wire ext_latch_clk_one, // External driver latch clock
  input wire ext_shift_clk_two, // External driver shift clock
  input wire ext_data_out, // External driver data
  input wire ext_alt_signal // External driver alternating signal
);
  reg [7:0] port8_output_latch_q;
  reg [7:0] port8_direction_reg_q;
  reg [3:0] port_a_output_latch_q;
  reg [3:0] port_a_direction_q;
  reg [4:0] lcd_pin_control_reg_q;
  reg [2:0] pwr_mode_q;
  reg [31:0] rdata_d;
  reg err_d;
  reg [7:0] p8_alt_sel;
  reg [7:0] p8_alt_val;
  wire [7:0] pa_rb;
  wire [3:0] segment_select_field;
  wire external_driver_select;
  wire seg_on;
  wire wr_en;
  wire rd_en;
  wire setup;

  // Mixes latch and pin levels per direction bit
  function [7:0] port_readback;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pins;
    begin
      port_readback = (dir & latch) | (~dir & pins);
    end
  endfunction

  // Decide whether paddr hits a 12-bit own offset
  function hit;
    input [17:0] addr;
    input [11:0] off;
    begin
      hit = (addr[17:12] == 6'h00) && (addr[11:0] == off);
    end
  endfunction

  assign segment_select_field = lcd_pin_control_reg_q[`LSP_LCD_SGS_MSB:`LSP_LCD_SGS_LSB];
  assign external_driver_select = lcd_pin_control_reg_q[`LSP_LCD_SGX_BIT];
  assign seg_on = (segment_select_field != 4'h0);
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;
  assign rd_en = setup & ~pwrite;
  assign pa_rb = port_readback({4'h0, port_a_direction_q}, {4'h0, port_a_output_latch_q},
    {4'h0, pa_pin_in});

  // Port8 function decode
  always @*
  begin
    p8_alt_sel = {8{seg_on}};
    p8_alt_val = lcd_column_drive[8:1];
    if (external_driver_select)
    begin
      p8_alt_sel[7:4] = 4'hF;
      p8_alt_val[7] = ext_latch_clk_one;
      p8_alt_val[6] = ext_shift_clk_two;
      p8_alt_val[5] = ext_data_out;
      p8_alt_val[4] = ext_alt_signal;
    end
  end

  // Port8 pins
  lsp_pin_cell u_p8_0
  (
    .pclk(pclk),
    .presetn(presetn),
    .alt_sel(p8_alt_sel[0]),
    .alt_val(p8_alt_val[0]),
    .dir_bit(port8_direction_reg_q[0]),
    .latch_bit(port8_output_latch_q[0]),
    .pwr_mode(pwr_mode_q),
    .pin_out(p8_pin_out[0]),
    .pin_oe(p8_pin_oe[0])
  );
  lsp_pin_cell u_p8_1
  (
    .pclk(pclk),
    .presetn(presetn),
    .alt_sel(p8_alt_sel[1]),
    .alt_val(p8_alt_val[1]),
    .dir_bit(port8_direction_reg_q[1]),
    .latch_bit(port8_output_latch_q[1]),
    .pwr_mode(pwr_mode_q),
    .pin_out(p8_pin_out[1]),
    .pin_oe(p8_pin_oe[1])
  );
  lsp_pin_cell u_p8_2
  (
    .pclk(pclk),
    .presetn(presetn),
    .alt_sel(p8_alt_sel[2]),
    .alt_val(p8_alt_val[2]),
    .dir_bit(port8_direction_reg_q[2]),
    .latch_bit(port8_output_latch_q[2]),
    .pwr_mode(pwr_mode_q),
    .pin_out(p8_pin_out[2]),
    .pin_oe(p8_pin_oe[2])
  );
  lsp_pin_cell u_p8_3
  (
    .pclk(pclk),
    .presetn(presetn),
    .alt_sel(p8_alt_sel[3]),
    .alt_val(p8_alt_val[3]),
    .dir_bit(port8_direction_reg_q[3]),
    .latch_bit(port8_output_latch_q[3]),
    .pwr_mode(pwr_mode_q),
    .pin_out(p8_pin_out[3]),
    .pin_oe(p8_pin_oe[3])
  );
  lsp_pin_cell u_p8_4
  (
    .pclk(pclk),
    .presetn(presetn),
    .alt_sel(p8_alt_sel[4]),
    .alt_val(p8_alt_val[4]),
    .dir_bit(port8_direction_reg_q[4]),
    .latch_bit(port8_output_latch_q[4]),
    .pwr_mode(pwr_mode_q),
    .pin_out(p8_pin_out[4]),
    .pin_oe(p8_pin_oe[4])
  );
  lsp_pin_cell u_p8_5
  (
    .pclk(pclk),
    .presetn(presetn),
    .alt_sel(p8_alt_sel[5]),
    .alt_val(p8_alt_val[5]),
    .dir_bit(port8_direction_reg_q[5]),
    .latch_bit(port8_output_latch_q[5]),
    .pwr_mode(pwr_mode_q),
    .pin_out(p8_pin_out[5]),
    .pin_oe(p8_pin_oe[5])
  );
  lsp_pin_cell u_p8_6
  (
    .pclk(pclk),
    .presetn(presetn),
    .alt_sel(p8_alt_sel[6]),
    .alt_val(p8_alt_val[6]),
    .dir_bit(port8_direction_reg_q[6]),
    .latch_bit(port8_output_latch_q[6]),
    .pwr_mode(pwr_mode_q),
    .pin_out(p8_pin_out[6]),
    .pin_oe(p8_pin_oe[6])
  );
  lsp_pin_cell u_p8_7
  (
    .pclk(pclk),
    .presetn(presetn),
    .alt_sel(p8_alt_sel[7]),
    .alt_val(p8_alt_val[7]),
    .dir_bit(port8_direction_reg_q[7]),
    .latch_bit(port8_output_latch_q[7]),
    .pwr_mode(pwr_mode_q),
    .pin_out(p8_pin_out[7]),
    .pin_oe(p8_pin_oe[7])
  );
  // Port A pins
  lsp_pin_cell u_pa_0
  (
    .pclk(pclk),
    .presetn(presetn),
    .alt_sel(seg_on),
    .alt_val(lcd_common_drive[0]),
    .dir_bit(port_a_direction_q[0]),
    .latch_bit(port_a_output_latch_q[0]),
    .pwr_mode(pwr_mode_q),
    .pin_out(pa_pin_out[0]),
    .pin_oe(pa_pin_oe[0])
  );
  lsp_pin_cell u_pa_1
  (
    .pclk(pclk),
    .presetn(presetn),
    .alt_sel(seg_on),
    .alt_val(lcd_common_drive[1]),
    .dir_bit(port_a_direction_q[1]),
    .latch_bit(port_a_output_latch_q[1]),
    .pwr_mode(pwr_mode_q),
    .pin_out(pa_pin_out[1]),
    .pin_oe(pa_pin_oe[1])
  );
  lsp_pin_cell u_pa_2
  (
    .pclk(pclk),
    .presetn(presetn),
    .alt_sel(seg_on),
    .alt_val(lcd_common_drive[2]),
    .dir_bit(port_a_direction_q[2]),
    .latch_bit(port_a_output_latch_q[2]),
    .pwr_mode(pwr_mode_q),
    .pin_out(pa_pin_out[2]),
    .pin_oe(pa_pin_oe[2])
  );
  lsp_pin_cell u_pa_3
  (
    .pclk(pclk),
    .presetn(presetn),
    .alt_sel(seg_on),
    .alt_val(lcd_common_drive[3]),
    .dir_bit(port_a_direction_q[3]),
    .latch_bit(port_a_output_latch_q[3]),
    .pwr_mode(pwr_mode_q),
    .pin_out(pa_pin_out[3]),
    .pin_oe(pa_pin_oe[3])
  );

  // Read decode
  always @*
  begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr == `LSP_ADDR_PA_LATCH)
      rdata_d = {24'h00_0000, 4'hF, pa_rb[3:0]};
    else if (paddr == `LSP_ADDR_PA_DIR)
      rdata_d = 32'h0000_00FF;
    else if (hit(paddr, `LSP_ADDR_P8_LATCH))
      rdata_d = {24'h00_0000, port_readback(port8_direction_reg_q,
        port8_output_latch_q, p8_pin_in)};
    else if (hit(paddr, `LSP_ADDR_P8_DIR))
      rdata_d = 32'h0000_00FF;
    else if (hit(paddr, `LSP_ADDR_P8_READ))
      rdata_d = {24'h00_0000, port8_output_latch_q};
    else if (hit(paddr, `LSP_ADDR_PA_READ))
      rdata_d = {24'h00_0000, 4'hF, port_a_output_latch_q};
    else if (hit(paddr, `LSP_ADDR_LCD_CTRL))
      rdata_d = {27'h000_0000, lcd_pin_control_reg_q};
    else if (hit(paddr, `LSP_ADDR_PWR_MODE))
      rdata_d = {29'h0000_0000, pwr_mode_q};
    else
      err_d = 1'b1;
  end

  // APB slave: no wait state, answer registered in setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & err_d;
      if (rd_en)
        prdata <= rdata_d;
    end
  end

  // Register writes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port8_output_latch_q <= `LSP_RST_P8;
      port8_direction_reg_q <= `LSP_RST_P8;
      port_a_output_latch_q <= `LSP_RST_PA_BITS;
      port_a_direction_q <= `LSP_RST_PA_BITS;
      lcd_pin_control_reg_q <= `LSP_RST_LCD_CTRL;
      pwr_mode_q <= `LSP_PM_ACTIVE;
    end
    else if (wr_en && pstrb[0])
    begin
      if (paddr == `LSP_ADDR_PA_LATCH)
        port_a_output_latch_q <= pwdata[3:0];
      else if (paddr == `LSP_ADDR_PA_DIR)
        port_a_direction_q <= pwdata[3:0];
      else if (hit(paddr, `LSP_ADDR_P8_LATCH))
        port8_output_latch_q <= pwdata[7:0];
      else if (hit(paddr, `LSP_ADDR_P8_DIR))
        port8_direction_reg_q <= pwdata[7:0];
      else if (hit(paddr, `LSP_ADDR_LCD_CTRL))
        lcd_pin_control_reg_q <= pwdata[4:0];
      else if (hit(paddr, `LSP_ADDR_PWR_MODE))
        pwr_mode_q <= pwdata[2:0];
    end
  end
endmodule

//--- tb/lsp_ports_monitor.sv
`timescale 1ns/10ps
module lsp_ports_monitor
(
  input wire pclk, // Clock
  input wire presetn, // Reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB write
  input wire [17:0] paddr, // APB address
  input wire [31:0] prdata, // APB read data
  input wire pready, // APB ready
  input wire pslverr, // APB error
  input wire [7:0] p8_pin_oe, // Port8 enables
  input wire [3:0] pa_pin_oe // Port A enables
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_decode: assert property (pready |-> pslverr == !(paddr inside {18'h3FF74, 18'h3FFB4,
    18'h00000, 18'h00004, 18'h00008, 18'h0000C, 18'h00010, 18'h00014}))
    else $error("bad decode");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_pa_high_ones: assert property (pready && !pwrite && paddr == 18'h3FF74 |->
    prdata[7:4] == 4'hF) else $error("latch high bits not ones");
  a_dir_reads_ones: assert property (pready && !pwrite && paddr == 18'h3FFB4 |->
    prdata[7:0] == 8'hFF) else $error("direction not all ones");
  a_reset_float: assert property (disable iff (1'b0) !presetn ##1 !presetn |->
    p8_pin_oe == 8'h00 && pa_pin_oe == 4'h0) else $error("pins driven in reset");
endmodule
bind lsp_ports lsp_ports_monitor u_mon (.*);

//--- tb/lsp_pin_model.sv
`timescale 1ns/10ps
// A driven pin shows the port value, a released one the outside level
module lsp_pin_model
#(
  parameter W = 8
)
(
  input wire [W-1:0] oe, // Port output enable
  input wire [W-1:0] drv, // Port output value
  input wire [W-1:0] ext, // Outside level
  output wire [W-1:0] lvl // Resolved pin level
);
  assign lvl = (oe & drv) | (~oe & ext);
endmodule

//--- tb/tb_lcd_shared_io_ports.sv
`timescale 1ns/10ps
module tb_lcd_shared_io_ports;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] p8i, p8o, p8e, ex8, l, d, e;
  logic [3:0] pai, pao, pae, exa, com, xd;
  logic [8:0] col;
  logic [23:0] s;
  logic [32:0] q[$];
  int bad_count, num_checks, cyc;
  lsp_ports DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .p8_pin_in(p8i), .p8_pin_out(p8o),
    .p8_pin_oe(p8e), .pa_pin_in(pai), .pa_pin_out(pao), .pa_pin_oe(pae),
    .lcd_column_drive(col), .lcd_common_drive(com), .ext_latch_clk_one(xd[3]),
    .ext_shift_clk_two(xd[2]), .ext_data_out(xd[1]), .ext_alt_signal(xd[0]));
  lsp_pin_model #(.W(8)) M8 (.oe(p8e), .drv(p8o), .ext(ex8), .lvl(p8i));
  lsp_pin_model #(.W(4)) MA (.oe(pae), .drv(pao), .ext(exa), .lvl(pai));
  task chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task apb(input logic w, input logic [17:0] a, input logic [7:0] v);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, v};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [17:0] a, input logic [32:0] exp);
    q.push_back(exp);
    apb(1'b0, a, 8'h00);
  endtask
  // Each read or error answer is matched against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && (!pwrite || pslverr))
      chk({pslverr, prdata}, q.pop_front());
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      bad_count++;
      results();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ex8, exa, com, xd, col} = '0;
    void'($urandom(30651));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    exa <= 4'hA;
    @(posedge pclk);
    chk({29'h0, pae}, 33'h0);
    rd(18'h3FFB4, 33'h0FF);
    rd(18'h0000C, 33'h0F0);
    rd(18'h3FF74, 33'h0FA);
    rd(18'h00020, 33'h1_0000_0000);
    $display("test reset done");
    repeat (4)
    begin
      l = 8'($urandom);
      d = 8'($urandom);
      e = 8'($urandom);
      exa <= e[3:0];
      ex8 <= e;
      apb(1'b1, 18'h3FF74, l);
      apb(1'b1, 18'h3FFB4, d);
      apb(1'b1, 18'h00000, l);
      apb(1'b1, 18'h00004, d);
      @(negedge pclk);
      chk({25'h0, pae, pao & d[3:0]}, {25'h0, d[3:0], l[3:0] & d[3:0]});
      chk({17'h0, p8e, p8o & d}, {17'h0, d, l & d});
      rd(18'h3FF74, {25'h0, 4'hF, (l[3:0] & d[3:0]) | (e[3:0] & ~d[3:0])});
      rd(18'h00000, {25'h0, (l & d) | (e & ~d)});
    end
    $display("test gpio done");
    col <= 9'($urandom);
    com <= 4'($urandom);
    xd <= 4'($urandom);
    apb(1'b1, 18'h00010, 8'h03);
    @(negedge pclk);
    chk({25'h0, pae, pao}, {25'h0, 4'hF, com});
    chk({17'h0, p8e, p8o}, {17'h0, 8'hFF, col[8:1]});
    apb(1'b1, 18'h00010, 8'h19);
    @(negedge pclk);
    chk({17'h0, p8e, p8o}, {17'h0, 8'hFF, xd, col[4:1]});
    apb(1'b1, 18'h00010, 8'h10);
    @(negedge pclk);
    chk({17'h0, p8e, p8o[7:4], 4'h0}, {17'h0, 4'hF, d[3:0], xd, 4'h0});
    apb(1'b1, 18'h00010, 8'h00);
    $display("test lcd done");
    apb(1'b1, 18'h00014, 8'h05);
    @(negedge pclk);
    chk({21'h0, p8e, pae}, 33'h0);
    for (int m = 2; m < 5; m++)
    begin
      apb(1'b1, 18'h00014, 8'(m));
      @(negedge pclk);
      s = {p8e, p8o, pae, pao};
      apb(1'b1, 18'h3FFB4, 8'($urandom));
      apb(1'b1, 18'h00004, 8'($urandom));
      @(negedge pclk);
      chk({9'h0, p8e, p8o, pae, pao}, {9'h0, s});
    end
    $display("test power done");
    results();
  end
endmodule
